/* File: tt_pkg.sv */
package tt_pkg;
  localparam int ADDR_W = 12;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_INTCTL  = 8'h0b;
  localparam logic [7:0] IDX_FLAGS   = 8'h0c;
  localparam logic [7:0] IDX_COUNT   = 8'h11;
  localparam logic [7:0] IDX_CTRL    = 8'h12;
  localparam logic [7:0] IDX_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_PERIOD  = 8'h92;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_PERIOD  = 8'hff;
  localparam logic [7:0] CTRL_MASK   = 8'h7f;
  localparam int BIT_GIE   = 7;
  localparam int BIT_PEIE  = 6;
  localparam int BIT_TFLAG = 1;
  localparam int CTL_RUN   = 2;
  localparam int CTL_POST  = 3;
  localparam int CTL_PRE   = 0;
  localparam logic [1:0] QDIV_LAST = 2'h3;
  localparam logic [3:0] PRE_LAST1  = 4'h0;
  localparam logic [3:0] PRE_LAST4  = 4'h3;
  localparam logic [3:0] PRE_LAST16 = 4'hf;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       en;
    logic [7:0] idx;
    logic [7:0] data;
  } tt_wr_type;

  function automatic logic [7:0] to_idx(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    if (a[1:0] != 2'h0 || a[ADDR_W-1:10] != '0)
      return 1'b0;
    return i == IDX_INTCTL || i == IDX_FLAGS || i == IDX_COUNT ||
           i == IDX_CTRL || i == IDX_ENABLES || i == IDX_PERIOD;
  endfunction
endpackage

/* File: tt_axil.sv */
`timescale 1ns/10ps
module tt_axil
(
  input  wire logic                      aclk,     // clock
  input  wire logic                      aresetn,  // sync reset, low
  input  wire logic                      ce,       // clock enable
  input  wire logic [tt_pkg::ADDR_W-1:0] awaddr,   // write address
  input  wire logic                      awvalid,  // write address valid
  output logic                           awready,  // write address ready
  input  wire logic [31:0]               wdata,    // write data
  input  wire logic [3:0]                wstrb,    // byte strobes
  input  wire logic                      wvalid,   // write data valid
  output logic                           wready,   // write data ready
  output logic [1:0]                     bresp,    // write response
  output logic                           bvalid,   // response valid
  input  wire logic                      bready,   // response ready
  input  wire logic [tt_pkg::ADDR_W-1:0] araddr,   // read address
  input  wire logic                      arvalid,  // read address valid
  output logic                           arready,  // read address ready
  output logic [31:0]                    rdata,    // read data
  output logic [1:0]                     rresp,    // read response
  output logic                           rvalid,   // read valid
  input  wire logic                      rready,   // read ready
  output tt_pkg::tt_wr_type              wr,       // register write pulse
  output logic [tt_pkg::ADDR_W-1:0]      rd_addr,  // read address to core
  input  wire logic [7:0]                rd_data   // read data from core
);
  logic                      aw_held;
  logic                      w_held;
  logic [tt_pkg::ADDR_W-1:0] aw_addr;
  logic [7:0]                w_byte;
  logic                      w_lane;

  assign rd_addr = araddr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_byte  <= 8'h00;
      w_lane  <= 1'b0;
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= tt_pkg::RESP_OKAY;
      wr      <= '0;
    end
    else if (ce)
    begin
      wr.en <= 1'b0;
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_held <= 1'b1;
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
        wready <= 1'b0;
      end
      if (aw_held && w_held && !bvalid)
      begin
        wr.en   <= tt_pkg::hit(aw_addr) && w_lane;
        wr.idx  <= tt_pkg::to_idx(aw_addr);
        wr.data <= w_byte;
        bresp   <= tt_pkg::hit(aw_addr) ? tt_pkg::RESP_OKAY
                                        : tt_pkg::RESP_SLVERR;
        bvalid  <= 1'b1;
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= tt_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= {24'h000000, rd_data};
        rresp   <= tt_pkg::hit(araddr) ? tt_pkg::RESP_OKAY
                                       : tt_pkg::RESP_SLVERR;
      end
      else if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule

/* File: tt_timer.sv */
// Overview of operation
// - prescale quarter clock by 1, 4, 16
// - count up, wrap to zero after period
// - period register read/write, resets to ones
// - counter read/write, reset clears it
// - matches pass four-bit postscaler, set flag
// - postscale ratio is select value plus one
// - run bit starts, clear stops counting
// - counter write, control write, reset clear scalers
// - control write keeps counter value
// - raw match pulse exported to serial port
// - counter exported as pwm time base
// - flag latched until software clears it
`timescale 1ns/10ps
module tt_timer
(
  input  wire logic                      aclk,         // oscillator clock
  input  wire logic                      aresetn,      // sync reset, low
  input  wire logic                      ce,           // clock enable
  input  wire logic [tt_pkg::ADDR_W-1:0] awaddr,       // write address
  input  wire logic                      awvalid,      // write addr valid
  output logic                           awready,      // write addr ready
  input  wire logic [31:0]               wdata,        // write data
  input  wire logic [3:0]                wstrb,        // byte strobes
  input  wire logic                      wvalid,       // write data valid
  output logic                           wready,       // write data ready
  output logic [1:0]                     bresp,        // write response
  output logic                           bvalid,       // response valid
  input  wire logic                      bready,       // response ready
  input  wire logic [tt_pkg::ADDR_W-1:0] araddr,       // read address
  input  wire logic                      arvalid,      // read addr valid
  output logic                           arready,      // read addr ready
  output logic [31:0]                    rdata,        // read data
  output logic [1:0]                     rresp,        // read response
  output logic                           rvalid,       // read valid
  input  wire logic                      rready,       // read ready
  output logic                           period_match, // match pulse
  output logic [7:0]                     pwm_timebase, // counter value
  output logic                           irq           // interrupt
);
  tt_pkg::tt_wr_type         wr;
  logic [tt_pkg::ADDR_W-1:0] rd_addr;
  logic [7:0]                rd_data;

  logic [7:0] interrupt_control;
  logic [7:0] peripheral_irq_flags;
  logic [7:0] peripheral_irq_enables;
  logic [7:0] tick_counter;
  logic [7:0] tick_timer_control;
  logic [7:0] period_compare;
  logic [1:0] qphase;
  logic [3:0] pre_cnt;
  logic [3:0] post_cnt;

  logic       tick_run;
  logic [1:0] prescale_select;
  logic [3:0] postscale_select;
  logic       wr_count;
  logic       wr_ctrl;
  logic       scaler_clr;
  logic       q_tick;
  logic       pre_tick;
  logic       match;
  logic       post_done;

  tt_axil u_axil
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr      (wr),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    case (sel)
      2'h0:    return tt_pkg::PRE_LAST1;
      2'h1:    return tt_pkg::PRE_LAST4;
      default: return tt_pkg::PRE_LAST16;
    endcase
  endfunction

  function automatic logic wr_to(input tt_pkg::tt_wr_type w,
                                 input logic [7:0] idx);
    return w.en && w.idx == idx;
  endfunction

  // ----------------------------------------------------------------
  // decoding and ticks
  // ----------------------------------------------------------------
  assign tick_run         = tick_timer_control[tt_pkg::CTL_RUN];
  assign prescale_select  = tick_timer_control[tt_pkg::CTL_PRE +: 2];
  assign postscale_select = tick_timer_control[tt_pkg::CTL_POST +: 4];
  assign wr_count   = wr_to(wr, tt_pkg::IDX_COUNT);
  assign wr_ctrl    = wr_to(wr, tt_pkg::IDX_CTRL);
  assign scaler_clr = wr_count || wr_ctrl;
  assign q_tick     = tick_run && qphase == tt_pkg::QDIV_LAST;
  assign pre_tick   = q_tick && !scaler_clr &&
                      pre_cnt == pre_last(prescale_select);
  assign match      = pre_tick && !wr_count &&
                      tick_counter == period_compare;
  assign post_done  = match && post_cnt == postscale_select;

  always_comb
  begin
    case (tt_pkg::to_idx(rd_addr))
      tt_pkg::IDX_INTCTL:  rd_data = interrupt_control;
      tt_pkg::IDX_FLAGS:   rd_data = peripheral_irq_flags;
      tt_pkg::IDX_COUNT:   rd_data = tick_counter;
      tt_pkg::IDX_CTRL:    rd_data = tick_timer_control;
      tt_pkg::IDX_ENABLES: rd_data = peripheral_irq_enables;
      tt_pkg::IDX_PERIOD:  rd_data = period_compare;
      default:             rd_data = tt_pkg::RST_ZERO;
    endcase
    if (!tt_pkg::hit(rd_addr))
      rd_data = tt_pkg::RST_ZERO;
  end

  // ----------------------------------------------------------------
  // quarter clock and prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      qphase <= 2'h0;
    else if (ce)
    begin
      if (scaler_clr)
        qphase <= 2'h0;
      else if (tick_run)
        qphase <= qphase + 2'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_cnt <= 4'h0;
    else if (ce)
    begin
      if (scaler_clr)
        pre_cnt <= 4'h0;
      else if (pre_tick)
        pre_cnt <= 4'h0;
      else if (q_tick)
        pre_cnt <= pre_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // counter and period
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_counter <= tt_pkg::RST_ZERO;
    else if (ce)
    begin
      if (wr_count)
        tick_counter <= wr.data;
      else if (match)
        tick_counter <= tt_pkg::RST_ZERO;
      else if (pre_tick)
        tick_counter <= tick_counter + 8'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      period_compare <= tt_pkg::RST_PERIOD;
    else if (ce && wr_to(wr, tt_pkg::IDX_PERIOD))
      period_compare <= wr.data;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_timer_control <= tt_pkg::RST_ZERO;
    else if (ce && wr_ctrl)
      tick_timer_control <= wr.data & tt_pkg::CTRL_MASK;
  end

  // ----------------------------------------------------------------
  // postscaler and flags
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      post_cnt <= 4'h0;
    else if (ce)
    begin
      if (scaler_clr)
        post_cnt <= 4'h0;
      else if (post_done)
        post_cnt <= 4'h0;
      else if (match)
        post_cnt <= post_cnt + 4'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      peripheral_irq_flags <= tt_pkg::RST_ZERO;
    else if (ce)
    begin
      if (wr_to(wr, tt_pkg::IDX_FLAGS))
        peripheral_irq_flags <= wr.data;
      if (post_done)
        peripheral_irq_flags[tt_pkg::BIT_TFLAG] <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      interrupt_control      <= tt_pkg::RST_ZERO;
      peripheral_irq_enables <= tt_pkg::RST_ZERO;
    end
    else if (ce)
    begin
      if (wr_to(wr, tt_pkg::IDX_INTCTL))
        interrupt_control <= wr.data;
      if (wr_to(wr, tt_pkg::IDX_ENABLES))
        peripheral_irq_enables <= wr.data;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      period_match <= 1'b0;
      pwm_timebase <= tt_pkg::RST_ZERO;
      irq          <= 1'b0;
    end
    else if (ce)
    begin
      period_match <= match;
      pwm_timebase <= tick_counter;
      irq <= interrupt_control[tt_pkg::BIT_GIE] &&
             interrupt_control[tt_pkg::BIT_PEIE] &&
             peripheral_irq_flags[tt_pkg::BIT_TFLAG] &&
             peripheral_irq_enables[tt_pkg::BIT_TFLAG];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wrap;
    ce && pre_tick && !wr_count && tick_counter == period_compare;
  endsequence

  sequence s_step;
    ce && pre_tick && !wr_count && tick_counter != period_compare;
  endsequence

  period_reset_a: assert property ($rose(aresetn) |->
    period_compare == 8'hff && tick_counter == 8'h00)
    else $error("period or counter wrong after reset");

  count_wrap_a: assert property (s_wrap |=>
    tick_counter == 8'h00 ##0 period_match)
    else $error("counter did not wrap on match");

  count_step_a: assert property (s_step |=>
    tick_counter == $past(tick_counter) + 8'h01)
    else $error("counter did not step");

  run_stop_a: assert property (ce && !tick_run && !wr_count |=>
    $stable(tick_counter))
    else $error("counter moved while stopped");

  ctrl_write_a: assert property (ce && wr_ctrl && !wr_count |=>
    $stable(tick_counter) && pre_cnt == 4'h0 && post_cnt == 4'h0)
    else $error("control write disturbed counter");

  count_write_a: assert property (ce && wr_count |=>
    tick_counter == $past(wr.data) && pre_cnt == 4'h0 &&
    post_cnt == 4'h0)
    else $error("counter write failed");

  pre_one_a: assert property (ce && tick_run && prescale_select == 2'h0 &&
    !scaler_clr && qphase == 2'h3 && tick_counter != period_compare
    |=> tick_counter == $past(tick_counter) + 8'h01)
    else $error("1:1 prescale missed a tick");

  flag_set_a: assert property (ce && post_done |=>
    peripheral_irq_flags[1] && post_cnt == 4'h0)
    else $error("postscaler did not set flag");

  flag_hold_a: assert property (peripheral_irq_flags[1] &&
    !wr_to(wr, tt_pkg::IDX_FLAGS) |=> peripheral_irq_flags[1])
    else $error("flag dropped without clear");

  irq_gate_a: assert property (ce && interrupt_control[7] &&
    interrupt_control[6] && peripheral_irq_flags[1] &&
    peripheral_irq_enables[1] |=> irq)
    else $error("interrupt not raised");

  match_out_a: assert property (ce |=>
    period_match == $past(match))
    else $error("match pulse not exported");

  timebase_a: assert property (ce |=>
    pwm_timebase == $past(tick_counter))
    else $error("time base lags counter");

  period_write_a: assert property (
    ce && wr_to(wr, tt_pkg::IDX_PERIOD) |=>
    period_compare == $past(wr.data))
    else $error("period write lost");

  post_step_a: assert property (ce && match && !post_done |=>
    post_cnt == $past(post_cnt) + 4'h1)
    else $error("postscaler did not step");

  flag_clear_a: assert property (
    ce && wr_to(wr, tt_pkg::IDX_FLAGS) && !post_done |=>
    peripheral_irq_flags == $past(wr.data))
    else $error("flag write lost");
endmodule

/* File: tt_testbench.sv */
`timescale 1ns/10ps
module testbench;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic                      aclk;
  logic                      aresetn;
  logic                      ce;
  logic [tt_pkg::ADDR_W-1:0] awaddr;
  logic                      awvalid;
  logic                      awready;
  logic [31:0]               wdata;
  logic [3:0]                wstrb;
  logic                      wvalid;
  logic                      wready;
  logic [1:0]                bresp;
  logic                      bvalid;
  logic                      bready;
  logic [tt_pkg::ADDR_W-1:0] araddr;
  logic                      arvalid;
  logic                      arready;
  logic [31:0]               rdata;
  logic [1:0]                rresp;
  logic                      rvalid;
  logic                      rready;
  logic                      period_match;
  logic [7:0]                pwm_timebase;
  logic                      irq;
  int                        num_errors;
  int                        tests_run;
  logic [31:0]               rv;
  logic [1:0]                rs;
  int                        g;
  int                        h;
  int                        c;
  int                        div [4] = '{1, 4, 16, 16};
  int                        posts [3] = '{0, 1, 15};

`define CHK(nm, e, s) \
  begin \
    tests_run++; \
    if ((s) !== (e)) \
    begin \
      num_errors++; \
      $display("BAD %s exp %0h got %0h", nm, e, s); \
    end \
  end

  tt_timer i_tt_timer
  (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .period_match(period_match), .pwm_timebase(pwm_timebase),
    .irq(irq)
  );

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // bus and helper tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] i, input logic [7:0] d,
                    output logic [1:0] r);
    awaddr  <= {2'h0, i, 2'h0};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!(bvalid && bready));
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] i, output logic [31:0] d,
                    output logic [1:0] r);
    araddr  <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!(rvalid && rready));
    d = rdata;
    r = rresp;
  endtask

  task automatic w(input logic [7:0] i, input logic [7:0] d);
    logic [1:0] r;
    wr(i, d, r);
    `CHK("bresp", tt_pkg::RESP_OKAY, r)
  endtask

  task automatic chk_rd(input logic [7:0] i, input logic [7:0] e,
                        input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    rd(i, d, r);
    `CHK(nm, {24'h0, e}, d)
    `CHK("rresp", tt_pkg::RESP_OKAY, r)
  endtask

  // edges until the next match pulse, measured from the current edge
  task automatic wait_pm(output int n);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (!period_match);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  task automatic chk_reset();
    chk_rd(tt_pkg::IDX_INTCTL, 8'h00, "intctl");
    chk_rd(tt_pkg::IDX_FLAGS, 8'h00, "flags");
    chk_rd(tt_pkg::IDX_COUNT, 8'h00, "count");
    chk_rd(tt_pkg::IDX_CTRL, 8'h00, "ctrl");
    chk_rd(tt_pkg::IDX_ENABLES, 8'h00, "enables");
    chk_rd(tt_pkg::IDX_PERIOD, 8'hff, "period");
  endtask

  task automatic endt(input string s);
    $display("test done: %s", s);
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    $display("BAD watchdog exp finished got hung");
    stop_test();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    aresetn = 1'b0;
    ce = 1'b1;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b1;
    num_errors = 0;
    tests_run = 0;
    do_reset();
    chk_reset();
    wr(8'h13, 8'h5a, rs);
    `CHK("unmapped bresp", tt_pkg::RESP_SLVERR, rs)
    rd(8'h13, rv, rs);
    `CHK("unmapped rresp", tt_pkg::RESP_SLVERR, rs)
    `CHK("unmapped rdata", 32'h0, rv)
    endt("reset and map");
    w(tt_pkg::IDX_PERIOD, 8'h5a);
    chk_rd(tt_pkg::IDX_PERIOD, 8'h5a, "period rw");
    wstrb <= 4'he;
    w(tt_pkg::IDX_PERIOD, 8'h33);
    wstrb <= 4'hf;
    chk_rd(tt_pkg::IDX_PERIOD, 8'h5a, "period lane off");
    w(tt_pkg::IDX_CTRL, 8'hfb);
    chk_rd(tt_pkg::IDX_CTRL, 8'h7b, "ctrl rw");
    w(tt_pkg::IDX_COUNT, 8'h05);
    chk_rd(tt_pkg::IDX_COUNT, 8'h05, "count rw");
    repeat (20) @(posedge aclk);
    chk_rd(tt_pkg::IDX_COUNT, 8'h05, "count stopped");
    `CHK("timebase", 8'h05, pwm_timebase)
    w(tt_pkg::IDX_CTRL, 8'h00);
    chk_rd(tt_pkg::IDX_COUNT, 8'h05, "count kept");
    w(tt_pkg::IDX_CTRL, 8'h04);
    repeat (40) @(posedge aclk);
    rd(tt_pkg::IDX_COUNT, rv, rs);
    `CHK("count runs", 1'b1, rv[7:0] !== 8'h05)
    endt("registers");
    w(tt_pkg::IDX_COUNT, 8'h00);
    w(tt_pkg::IDX_PERIOD, 8'h03);
    for (int k = 0; k < 4; k++)
    begin
      w(tt_pkg::IDX_CTRL, 8'h04 | 8'(k));
      wait_pm(g);
      wait_pm(g);
      `CHK("match gap", 16 * div[k], g)
    end
    endt("prescaler");
    w(tt_pkg::IDX_PERIOD, 8'h00);
    w(tt_pkg::IDX_CTRL, 8'h05);
    wait_pm(g);
    w(tt_pkg::IDX_COUNT, 8'h00);
    wait_pm(g);
    `CHK("edges to match", 17, g)
    repeat (5) @(posedge aclk);
    w(tt_pkg::IDX_COUNT, 8'h00);
    wait_pm(h);
    `CHK("match after count write", g, h)
    endt("scaler clear");
    w(tt_pkg::IDX_PERIOD, 8'h01);
    w(tt_pkg::IDX_INTCTL, 8'hc0);
    w(tt_pkg::IDX_ENABLES, 8'h02);
    foreach (posts[j])
    begin
      w(tt_pkg::IDX_CTRL, 8'h00);
      w(tt_pkg::IDX_FLAGS, 8'h00);
      w(tt_pkg::IDX_CTRL, 8'h04 | 8'(posts[j] * 8));
      c = 0;
      while (!irq)
      begin
        @(posedge aclk);
        if (period_match)
          c++;
      end
      `CHK("matches to flag", posts[j] + 1, c)
    end
    w(tt_pkg::IDX_CTRL, 8'h00);
    chk_rd(tt_pkg::IDX_FLAGS, 8'h02, "flag latched");
    w(tt_pkg::IDX_ENABLES, 8'h00);
    repeat (2) @(posedge aclk);
    `CHK("irq masked", 1'b0, irq)
    w(tt_pkg::IDX_ENABLES, 8'h02);
    repeat (2) @(posedge aclk);
    `CHK("irq unmasked", 1'b1, irq)
    w(tt_pkg::IDX_INTCTL, 8'h80);
    repeat (2) @(posedge aclk);
    `CHK("irq peripheral off", 1'b0, irq)
    w(tt_pkg::IDX_INTCTL, 8'h40);
    repeat (2) @(posedge aclk);
    `CHK("irq global off", 1'b0, irq)
    w(tt_pkg::IDX_INTCTL, 8'hc0);
    w(tt_pkg::IDX_FLAGS, 8'h00);
    repeat (2) @(posedge aclk);
    `CHK("irq cleared", 1'b0, irq)
    chk_rd(tt_pkg::IDX_FLAGS, 8'h00, "flag cleared");
    endt("postscaler and flag");
    w(tt_pkg::IDX_CTRL, 8'h04);
    repeat (10) @(posedge aclk);
    ce <= 1'b0;
    repeat (2) @(posedge aclk);
    g = pwm_timebase;
    repeat (20) @(posedge aclk);
    `CHK("frozen count", g, pwm_timebase)
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    do_reset();
    chk_reset();
    `CHK("irq after reset", 1'b0, irq)
    endt("reset mid run");
    stop_test();
  end
endmodule
